// ===== hw/scu_top.sv
// Clock selection, mode registers, start control and interrupts of a four-channel serial unit.
// Assumes an APB master on clk_in; pins are asynchronous, channel events come from logic on clk_in.
//
// Design decision made here: the APB register port.
module scu_top (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [scu_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [scu_pkg::NUM_CH-1:0][scu_pkg::DIV_W-1:0] divider_field_in,
    input wire logic [scu_pkg::NUM_CH-1:0] serial_clock_pin_in,
    input wire logic [scu_pkg::NUM_CH-1:0] uart_receive_pin_in,
    input wire logic [scu_pkg::NUM_CH-1:0] transfer_end_in,
    input wire logic [scu_pkg::NUM_CH-1:0] buffer_to_shift_in,
    output logic shared_op_clock_a_out,
    output logic shared_op_clock_b_out,
    output scu_pkg::scu_chan_cfg_t [scu_pkg::NUM_CH-1:0] chan_cfg_out,
    output scu_pkg::scu_chan_status_t [scu_pkg::NUM_CH-1:0] chan_status_out,
    output logic [scu_pkg::NUM_CH-1:0] chan_irq_out,
    output logic irq_out
);
    import scu_pkg::*;

    logic [7:0] prescaler_select_reg;
    logic [15:0] channel_mode_reg [NUM_CH];
    logic [NUM_CH-1:0] channel_running_flag;
    logic [NUM_CH-1:0] chan_active;
    logic [NUM_CH-1:0] irq_status;
    logic [NUM_CH-1:0] irq_mask;
    logic [NUM_CH-1:0] irq_event;
    logic [NUM_CH-1:0] next_irq_status;
    logic [NUM_CH-1:0] start_req;
    logic [NUM_CH-1:0] stop_req;
    logic [NUM_CH-1:0] rx_edge;
    logic [NUM_CH-1:0] sck_rise;
    logic [NUM_CH-1:0] op_tick;
    logic [NUM_CH-1:0] xfer_tick;
    logic [NUM_CH-1:0] start_pulse;
    logic [NUM_CH-1:0] rx_data;
    logic [NUM_CH-1:0] rx_prev;
    logic [NUM_CH-1:0] sck_prev;
    logic [2*NUM_CH-1:0] pin_meta;
    logic [2*NUM_CH-1:0] pin_sync;
    logic [NUM_CH-1:0] sck_sync;
    logic [NUM_CH-1:0] rx_sync;
    logic any_running;
    logic access;
    logic wr_en;
    logic [21:0] word_idx;
    logic hit;
    logic [NUM_CH-1:0] hit_mode;
    logic hit_prs;
    logic hit_prs_low;
    logic hit_start;
    logic hit_stop;
    logic hit_running;
    logic hit_status;
    logic hit_mask;
    logic [31:0] next_rdata;
    logic tick_a;
    logic tick_b;

    assign any_running = |channel_running_flag;
    assign access = psel_in & penable_in;
    assign pready_out = 1'b1;
    assign word_idx = paddr_in[ADDR_W-1:2];

    // Address decode of the register file.
    always_comb begin
        hit_mode[0] = (word_idx == IDX_MODE_CH0);
        hit_mode[1] = (word_idx == IDX_MODE_CH1);
        hit_mode[2] = (word_idx == IDX_MODE_CH2);
        hit_mode[3] = (word_idx == IDX_MODE_CH3);
        hit_prs = (word_idx == IDX_PRESCALER);
        hit_prs_low = (word_idx == IDX_PRESCALER_LOW);
        hit_start = (word_idx == IDX_START);
        hit_stop = (word_idx == IDX_STOP);
        hit_running = (word_idx == IDX_RUNNING);
        hit_status = (word_idx == IDX_IRQ_STATUS);
        hit_mask = (word_idx == IDX_IRQ_MASK);
        hit = (|hit_mode) | hit_prs | hit_prs_low | hit_start | hit_stop | hit_running | hit_status | hit_mask;
    end

    assign pslverr_out = access & ~hit;
    assign wr_en = access & pwrite_in & hit;

    // Read data is gathered in the setup cycle and held for the access cycle.
    always_comb begin
        next_rdata = 32'h00000000;
        case (1'b1)
            hit_mode[0]: next_rdata = {16'h0000, channel_mode_reg[0]};
            hit_mode[1]: next_rdata = {16'h0000, channel_mode_reg[1]};
            hit_mode[2]: next_rdata = {16'h0000, channel_mode_reg[2]};
            hit_mode[3]: next_rdata = {16'h0000, channel_mode_reg[3]};
            hit_prs: next_rdata = {24'h000000, prescaler_select_reg};
            hit_prs_low: next_rdata = {24'h000000, prescaler_select_reg};
            hit_running: next_rdata = {28'h0000000, channel_running_flag};
            hit_status: next_rdata = {28'h0000000, irq_status};
            hit_mask: next_rdata = {28'h0000000, irq_mask};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prdata_out <= 32'h00000000;
        end else if (psel_in && !penable_in) begin
            prdata_out <= next_rdata;
        end
    end

    // Prescaler register: word and low-byte alias, frozen while any channel runs.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prescaler_select_reg <= PRESCALER_RESET;
        end else if (wr_en && (hit_prs || hit_prs_low) && pstrb_in[0] && !any_running) begin
            prescaler_select_reg <= pwdata_in[7:0];
        end
    end

    // Start and stop requests are single-cycle writes of ones.
    assign start_req = (wr_en && hit_start && pstrb_in[0]) ? pwdata_in[NUM_CH-1:0] : 4'h0;
    assign stop_req = (wr_en && hit_stop && pstrb_in[0]) ? pwdata_in[NUM_CH-1:0] : 4'h0;

    scu_prescaler u_prs_a (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .field_in(prescaler_select_reg[PRS_A_LSB +: PRS_FIELD_W]),
        .tick_out(tick_a)
    );

    scu_prescaler u_prs_b (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .field_in(prescaler_select_reg[PRS_B_LSB +: PRS_FIELD_W]),
        .tick_out(tick_b)
    );

    assign shared_op_clock_a_out = tick_a;
    assign shared_op_clock_b_out = tick_b;

    // Two-stage synchronisers for the serial clock and receive pins.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_meta <= 8'hFF;
            pin_sync <= 8'hFF;
        end else begin
            pin_meta <= {uart_receive_pin_in, serial_clock_pin_in};
            pin_sync <= pin_meta;
        end
    end

    assign sck_sync = pin_sync[NUM_CH-1:0];
    assign rx_sync = pin_sync[2*NUM_CH-1:NUM_CH];

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i = i + 1) begin : g_chan
            scu_chan_state_t state;
            logic [7:0] div_count;
            logic [15:0] wr_merged;
            logic trig_wait;
            logic is_uart;

            always_comb begin
                wr_merged[15:8] = pstrb_in[1] ? pwdata_in[15:8] : channel_mode_reg[i][15:8];
                wr_merged[7:0] = pstrb_in[0] ? pwdata_in[7:0] : channel_mode_reg[i][7:0];
            end

            // Mode register; while the channel runs only the interrupt source follows writes.
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    channel_mode_reg[i] <= MODE_RESET;
                end else if (wr_en && hit_mode[i]) begin
                    if (channel_running_flag[i]) begin
                        channel_mode_reg[i] <= (channel_mode_reg[i] & ~MODE_IRQ_SRC_MASK) |
                            (wr_merged & MODE_IRQ_SRC_MASK);
                    end else if (CH_HAS_TRIGGER[i]) begin
                        channel_mode_reg[i] <= (wr_merged & MODE_WMASK_TRIG) | MODE_FORCED_ONE;
                    end else begin
                        channel_mode_reg[i] <= (wr_merged & MODE_WMASK_PLAIN) | MODE_FORCED_ONE;
                    end
                end
            end

            assign chan_cfg_out[i].op_clk_sel = channel_mode_reg[i][MODE_OP_CLK_BIT];
            assign chan_cfg_out[i].xfer_clk_sel = channel_mode_reg[i][MODE_XFER_CLK_BIT];
            assign chan_cfg_out[i].start_trig_sel = channel_mode_reg[i][MODE_TRIG_BIT];
            assign chan_cfg_out[i].rx_invert = channel_mode_reg[i][MODE_INV_BIT];
            assign chan_cfg_out[i].op_mode = channel_mode_reg[i][MODE_OPM_LSB +: 2];
            assign chan_cfg_out[i].irq_source_sel = channel_mode_reg[i][MODE_IRQ_BIT];

            assign is_uart = (chan_cfg_out[i].op_mode == OPM_UART);
            assign trig_wait = CH_HAS_TRIGGER[i] & chan_cfg_out[i].start_trig_sel;

            // Channel operation clock taken from one of the shared clocks.
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    op_tick[i] <= 1'b0;
                end else begin
                    op_tick[i] <= chan_cfg_out[i].op_clk_sel ? tick_b : tick_a;
                end
            end

            // Receive edge detector sampled on the operation clock.
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    rx_prev[i] <= 1'b1;
                end else if (op_tick[i]) begin
                    rx_prev[i] <= rx_sync[i];
                end
            end

            assign rx_edge[i] = op_tick[i] & (chan_cfg_out[i].rx_invert ? (~rx_prev[i] & rx_sync[i]) :
                (rx_prev[i] & ~rx_sync[i]));

            // Receive data polarity, inverted only in UART mode.
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    rx_data[i] <= 1'b1;
                end else begin
                    rx_data[i] <= (is_uart && chan_cfg_out[i].rx_invert) ? ~rx_sync[i] : rx_sync[i];
                end
            end

            // Start control: software start, then optional wait for a receive edge.
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    state <= SCU_IDLE;
                end else begin
                    case (state)
                        SCU_IDLE: begin
                            if (start_req[i]) begin
                                state <= trig_wait ? SCU_ARMED : SCU_RUN;
                            end
                        end
                        SCU_ARMED: begin
                            if (stop_req[i]) begin
                                state <= SCU_IDLE;
                            end else if (rx_edge[i]) begin
                                state <= SCU_RUN;
                            end
                        end
                        SCU_RUN: begin
                            if (stop_req[i]) begin
                                state <= SCU_IDLE;
                            end
                        end
                        default: begin
                            state <= SCU_IDLE;
                        end
                    endcase
                end
            end

            assign channel_running_flag[i] = (state != SCU_IDLE);
            assign chan_active[i] = (state == SCU_RUN);

            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    start_pulse[i] <= 1'b0;
                end else begin
                    start_pulse[i] <= ((state == SCU_IDLE) && start_req[i] && !trig_wait) ||
                        ((state == SCU_ARMED) && !stop_req[i] && rx_edge[i]);
                end
            end

            // External serial clock rising edge.
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    sck_prev[i] <= 1'b1;
                end else begin
                    sck_prev[i] <= sck_sync[i];
                end
            end

            assign sck_rise[i] = sck_sync[i] & ~sck_prev[i];

            // Internal transfer clock divides the operation clock by twice the divider plus two.
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    div_count <= 8'h00;
                end else if (!chan_active[i]) begin
                    div_count <= 8'h00;
                end else if (op_tick[i]) begin
                    if (div_count >= {divider_field_in[i], 1'b1}) begin
                        div_count <= 8'h00;
                    end else begin
                        div_count <= div_count + 8'h01;
                    end
                end
            end

            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    xfer_tick[i] <= 1'b0;
                end else if (chan_cfg_out[i].xfer_clk_sel) begin
                    xfer_tick[i] <= chan_active[i] & sck_rise[i];
                end else begin
                    xfer_tick[i] <= chan_active[i] & op_tick[i] &
                        (div_count >= {divider_field_in[i], 1'b1});
                end
            end

            // Interrupt source selection per channel.
            assign irq_event[i] = chan_active[i] & (chan_cfg_out[i].irq_source_sel ?
                buffer_to_shift_in[i] : transfer_end_in[i]);

            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    chan_irq_out[i] <= 1'b0;
                end else begin
                    chan_irq_out[i] <= irq_event[i];
                end
            end

            assign chan_status_out[i].op_tick = op_tick[i];
            assign chan_status_out[i].xfer_tick = xfer_tick[i];
            assign chan_status_out[i].running = channel_running_flag[i];
            assign chan_status_out[i].active = chan_active[i];
            assign chan_status_out[i].start_pulse = start_pulse[i];
            assign chan_status_out[i].rx_data = rx_data[i];
        end
    endgenerate

    // Sticky interrupt status; a new event wins over a write-one clear.
    always_comb begin
        next_irq_status = irq_status;
        if (wr_en && hit_status && pstrb_in[0]) begin
            next_irq_status = next_irq_status & ~pwdata_in[NUM_CH-1:0];
        end
        next_irq_status = next_irq_status | irq_event;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_status <= 4'h0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_mask <= IRQ_MASK_RESET;
        end else if (wr_en && hit_mask && pstrb_in[0]) begin
            irq_mask <= pwdata_in[NUM_CH-1:0];
        end
    end

    assign irq_out = |(irq_status & irq_mask);
endmodule

// ===== hw/scu_pkg.sv
// Constants, register map and carrier types of the serial unit configuration block.
// Assumes a single 25 MHz peripheral clock and an APB master with 32-bit data.
// Notes on behaviour
// - Two shared operation clocks from prescaler nibbles.
// - Field value k divides clock by two^k.
// - Prescaler takes 16-bit writes and low-byte alias.
// - Prescaler resets to zero; upper byte stays zero.
// - Mode resets 0x0020; bit 5 one, reserved zero.
// - Bit 15 picks shared clock A or B.
// - Transfer clock: divided operation clock or external clock.
// - Operation clock drives edge detector; transfer clock shifts.
// - Channels 1, 3: start by software or receive edge.
// - Transfer begins once start source satisfied after start.
// - Receive inversion selects start edge and, in UART mode only, data polarity.
// - Mode field: 00 clocked, 01 UART, 10 two-wire.
// - Interrupt source 0: interrupt at transfer end.
// - Interrupt source 1: interrupt on buffer-to-shift move.
package scu_pkg;
    localparam int NUM_CH = 4;
    localparam int DIV_W = 7;
    localparam int PRS_FIELD_W = 4;
    localparam int PRS_A_LSB = 0;
    localparam int PRS_B_LSB = 4;
    localparam int ADDR_W = 24;

    // Register indices; the byte address is four times the index.
    localparam logic [21:0] IDX_MODE_CH0 = 22'h0F0110;
    localparam logic [21:0] IDX_MODE_CH1 = 22'h0F0112;
    localparam logic [21:0] IDX_MODE_CH2 = 22'h0F0114;
    localparam logic [21:0] IDX_MODE_CH3 = 22'h0F0116;
    localparam logic [21:0] IDX_PRESCALER = 22'h0F0126;
    localparam logic [21:0] IDX_PRESCALER_LOW = 22'h0F0128;
    localparam logic [21:0] IDX_START = 22'h0F0130;
    localparam logic [21:0] IDX_STOP = 22'h0F0131;
    localparam logic [21:0] IDX_RUNNING = 22'h0F0132;
    localparam logic [21:0] IDX_IRQ_STATUS = 22'h0F0133;
    localparam logic [21:0] IDX_IRQ_MASK = 22'h0F0134;

    localparam logic [15:0] MODE_RESET = 16'h0020;
    localparam logic [15:0] MODE_FORCED_ONE = 16'h0020;
    localparam logic [15:0] MODE_WMASK_TRIG = 16'hC147;
    localparam logic [15:0] MODE_WMASK_PLAIN = 16'hC007;
    localparam logic [15:0] MODE_IRQ_SRC_MASK = 16'h0001;
    localparam logic [7:0] PRESCALER_RESET = 8'h00;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam logic [3:0] CH_HAS_TRIGGER = 4'hA;

    localparam int MODE_OP_CLK_BIT = 15;
    localparam int MODE_XFER_CLK_BIT = 14;
    localparam int MODE_TRIG_BIT = 8;
    localparam int MODE_INV_BIT = 6;
    localparam int MODE_OPM_LSB = 1;
    localparam int MODE_IRQ_BIT = 0;

    localparam logic [1:0] OPM_CLOCKED = 2'h0;
    localparam logic [1:0] OPM_UART = 2'h1;
    localparam logic [1:0] OPM_TWO_WIRE = 2'h2;

    typedef struct packed {
        logic op_clk_sel;
        logic xfer_clk_sel;
        logic start_trig_sel;
        logic rx_invert;
        logic [1:0] op_mode;
        logic irq_source_sel;
    } scu_chan_cfg_t;

    typedef struct packed {
        logic op_tick;
        logic xfer_tick;
        logic running;
        logic active;
        logic start_pulse;
        logic rx_data;
    } scu_chan_status_t;

    typedef enum logic [2:0] {
        SCU_IDLE = 3'b001,
        SCU_ARMED = 3'b010,
        SCU_RUN = 3'b100
    } scu_chan_state_t;
endpackage

// ===== hw/scu_prescaler.sv
// Power-of-two divider producing a one-cycle tick of the peripheral clock.
// Assumes the field input is held steady while channels are running.
module scu_prescaler (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [scu_pkg::PRS_FIELD_W-1:0] field_in,
    output logic tick_out
);
    import scu_pkg::*;

    logic [14:0] count;
    logic [14:0] mask;

    // A field of k passes one tick out of every two to the power k.
    always_comb begin
        mask = 15'((16'h0001 << field_in) - 16'h0001);
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count <= 15'h0000;
        end else begin
            count <= count + 15'h0001;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= ((count & mask) == mask);
        end
    end
endmodule

// ===== tb/scu_top_chk.sv
// Concurrent checks of the serial unit configuration block.
// Assumes it is bound to scu_top and sees only its ports.
module scu_top_chk (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [scu_pkg::NUM_CH-1:0] transfer_end_in,
    input wire logic [scu_pkg::NUM_CH-1:0] buffer_to_shift_in,
    input wire logic shared_op_clock_a_out,
    input wire logic shared_op_clock_b_out,
    input wire scu_pkg::scu_chan_cfg_t [scu_pkg::NUM_CH-1:0] chan_cfg_out,
    input wire scu_pkg::scu_chan_status_t [scu_pkg::NUM_CH-1:0] chan_status_out,
    input wire logic [scu_pkg::NUM_CH-1:0] chan_irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import scu_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    err_phase_a: assert property (pslverr_out |-> psel_in && penable_in)
        else $error("error response outside an access phase");
    ready_high_a: assert property (psel_in && penable_in |-> pready_out)
        else $error("access phase without ready");
    trig_fixed_a: assert property (!chan_cfg_out[0].start_trig_sel && !chan_cfg_out[2].start_trig_sel
        && !chan_cfg_out[0].rx_invert && !chan_cfg_out[2].rx_invert)
        else $error("trigger or invert bit set on channel 0 or 2");
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        op_tick_a: assert property (chan_status_out[i].op_tick == $past(chan_cfg_out[i].op_clk_sel ?
            shared_op_clock_b_out : shared_op_clock_a_out)) else $error("operation tick from wrong clock");
        irq_src_a: assert property (chan_irq_out[i] == $past(chan_status_out[i].active &&
            (chan_cfg_out[i].irq_source_sel ? buffer_to_shift_in[i] : transfer_end_in[i])))
            else $error("channel interrupt not from selected source");
        cfg_frozen_a: assert property ($past(chan_status_out[i].running) |-> $stable(chan_cfg_out[i][6:1]))
            else $error("mode changed while channel operates");
        xfer_gate_a: assert property (chan_status_out[i].xfer_tick |-> $past(chan_status_out[i].active))
            else $error("transfer tick while channel idle");
        active_run_a: assert property (chan_status_out[i].active |-> chan_status_out[i].running)
            else $error("active channel not flagged running");
    end
endmodule
bind scu_top scu_top_chk chk_u (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .transfer_end_in(transfer_end_in),
    .buffer_to_shift_in(buffer_to_shift_in), .shared_op_clock_a_out(shared_op_clock_a_out),
    .shared_op_clock_b_out(shared_op_clock_b_out), .chan_cfg_out(chan_cfg_out),
    .chan_status_out(chan_status_out), .chan_irq_out(chan_irq_out));

// ===== tb/scu_top_test.sv
// Self-checking testbench of the serial unit configuration block.
// Assumes scu_top with an APB slave on a 25 MHz clock.
module scu_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import scu_pkg::*;
    logic clk_in, nrst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic [ADDR_W-1:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, lfsr;
    logic [NUM_CH-1:0][DIV_W-1:0] divider_field_in;
    logic [NUM_CH-1:0] serial_clock_pin_in, uart_receive_pin_in, transfer_end_in, buffer_to_shift_in, chan_irq_out;
    logic shared_op_clock_a_out, shared_op_clock_b_out, irq_out;
    scu_chan_cfg_t [NUM_CH-1:0] chan_cfg_out;
    scu_chan_status_t [NUM_CH-1:0] chan_status_out;
    logic [31:0] exp_q[$];
    int num_errors = 0;
    int compares = 0;
    int na, nb;
    scu_top dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(4'hF),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .divider_field_in(divider_field_in), .serial_clock_pin_in(serial_clock_pin_in),
        .uart_receive_pin_in(uart_receive_pin_in), .transfer_end_in(transfer_end_in),
        .buffer_to_shift_in(buffer_to_shift_in), .shared_op_clock_a_out(shared_op_clock_a_out),
        .shared_op_clock_b_out(shared_op_clock_b_out), .chan_cfg_out(chan_cfg_out),
        .chan_status_out(chan_status_out), .chan_irq_out(chan_irq_out), .irq_out(irq_out));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [21:0] midx(input int i);
        return IDX_MODE_CH0 + 22'(2 * i);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [21:0] idx, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= {idx, 2'b00};
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(negedge clk_in);
    endtask
    task automatic wr(input logic [21:0] idx, input logic [31:0] d);
        xfer(1'b1, idx, d);
    endtask
    task automatic rd(input logic [21:0] idx, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b0, idx, 32'h0);
    endtask
    task automatic pulse(input logic [3:0] ends, input logic [3:0] moves);
        @(posedge clk_in);
        transfer_end_in <= ends;
        buffer_to_shift_in <= moves;
        @(posedge clk_in);
        transfer_end_in <= 4'h0;
        buffer_to_shift_in <= 4'h0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    task automatic pin(input logic v);
        @(posedge clk_in);
        uart_receive_pin_in <= {2'b11, v, 1'b1};
        repeat (8) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    always @(posedge clk_in) begin
        if (psel_in && penable_in && !pwrite_in && pready_out) begin
            chk(prdata_out, exp_q.pop_front());
        end
    end
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        num_errors++;
        print_verdict();
    end
    initial begin
        {nrst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, transfer_end_in, buffer_to_shift_in} = '0;
        uart_receive_pin_in = 4'hF;
        lfsr = 32'hE8F6;
        divider_field_in = 28'(lfsr);
        serial_clock_pin_in = lfsr[7:4];
        repeat (20) @(posedge clk_in);
        nrst_in <= 1'b1;
        for (int i = 0; i < 4; i++) rd(midx(i), 32'h20);
        rd(IDX_PRESCALER, 32'h0);
        rd(22'h0F0100, 32'h0);
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            wr(midx(i), lfsr);
            rd(midx(i), {16'h0, lfsr[15:0] & ((i % 2) ? 16'hC147 : 16'hC007) | 16'h0020});
        end
        for (int m = 0; m < 3; m++) begin
            wr(IDX_MODE_CH0, 32'h20 | (m << 1));
            chk({30'h0, chan_cfg_out[0].op_mode}, m);
        end
        wr(IDX_PRESCALER, 32'hFFFF_FF53);
        rd(IDX_PRESCALER, 32'h53);
        wr(IDX_PRESCALER_LOW, 32'h21);
        rd(IDX_PRESCALER, 32'h21);
        for (int k = 0; k < 6; k++) begin
            wr(IDX_PRESCALER, (k << 4) | (5 - k));
            repeat (64) @(posedge clk_in);
            na = 0;
            nb = 0;
            repeat (64) begin
                @(posedge clk_in);
                na += shared_op_clock_a_out;
                nb += shared_op_clock_b_out;
            end
            chk(32'(na), 64 >> (5 - k));
            chk(32'(nb), 64 >> k);
        end
        wr(IDX_MODE_CH0, 32'h20);
        wr(IDX_START, 32'h1);
        rd(IDX_RUNNING, 32'h1);
        wr(IDX_PRESCALER, 32'h77);
        rd(IDX_PRESCALER, 32'h50);
        wr(IDX_MODE_CH0, 32'hC0A5);
        rd(IDX_MODE_CH0, 32'h21);
        wr(IDX_IRQ_MASK, 32'h1);
        for (int s = 0; s < 2; s++) begin
            wr(IDX_MODE_CH0, 32'h20 | s);
            pulse({3'h0, s == 1}, {3'h0, s == 0});
            rd(IDX_IRQ_STATUS, 32'h0);
            pulse({3'h0, s == 0}, {3'h0, s == 1});
            rd(IDX_IRQ_STATUS, 32'h1);
            chk(irq_out, 32'h1);
            wr(IDX_IRQ_MASK, 32'h0);
            chk(irq_out, 32'h0);
            wr(IDX_IRQ_MASK, 32'h1);
            wr(IDX_IRQ_STATUS, 32'h1);
            rd(IDX_IRQ_STATUS, 32'h0);
        end
        wr(IDX_STOP, 32'hF);
        wr(IDX_PRESCALER, 32'h0);
        for (int s = 0; s < 2; s++) begin
            wr(midx(1), 32'h0122 | (s << 6));
            pin(s == 0);
            wr(IDX_START, 32'h2);
            pin(s == 0);
            chk(chan_status_out[1].active, 32'h0);
            pin(s == 1);
            chk(chan_status_out[1].active, 32'h1);
            chk(chan_status_out[1].rx_data, 32'h0);
            wr(IDX_STOP, 32'h2);
        end
        wr(IDX_MODE_CH0, 32'h4020);
        wr(IDX_START, 32'h1);
        na = 0;
        repeat (4) begin
            @(posedge clk_in);
            serial_clock_pin_in[0] <= ~serial_clock_pin_in[0];
            repeat (5) begin
                @(posedge clk_in);
                na += chan_status_out[0].xfer_tick;
            end
        end
        chk(32'(na), 32'h2);
        print_verdict();
    end
endmodule
